/* link_irq_pkg.sv */
// Constants for the lower interrupt event bits of the link controller
package link_irq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int EVT_W = 21;
  localparam logic [7:0] EVT_SET_OFS = 8'h80;
  localparam logic [7:0] EVT_CLR_OFS = 8'h84;
  localparam int B_CYCLE = 20;
  localparam int B_PHY = 19;
  localparam int B_BUSRST = 17;
  localparam int B_SELFID = 16;
  localparam int B_LOCKERR = 9;
  localparam int B_PWERR = 8;
  localparam int B_ISORX = 7;
  localparam int B_ISOTX = 6;
  localparam int B_RESPONSE_PACKET_RECEIVED = 5;
  localparam int B_REQUEST_PACKET_RECEIVED = 4;
  localparam int B_DMA_LO = 0;
  localparam int DMA_N = 4;
  localparam int MASTER_EN_BIT = 31;
  // Bits that latch events; summaries and reserved positions excluded
  localparam logic [20:0] LATCH_MASK = 21'h1B033F;
  // Bits that read back; the rest are reserved and read zero
  localparam logic [20:0] READ_MASK = 21'h1B03FF;
  localparam logic [20:0] EVT_RESET = 21'h000000;
  localparam logic [47:0] PW_OFS_RESET = 48'h000000000000;
  localparam logic [15:0] PW_SRC_RESET = 16'h0000;
endpackage

/* link_interrupt_event_lower_bits.sv */
// Lower interrupt event register bits with set and clear register ports
//
// Overview of operation
// - Cycle event sets whenever the low bit of the cycle number toggles.
// - Physical-layer event sets on a PHY interrupt request in a status transfer.
// - Bus-reset event sets when the PHY reports entering bus reset.
// - Self-ID done event sets at end of initialization only when acceptance enabled.
// - Self-ID done event clears in the same cycle bus-reset event becomes set.
// - Host clears of bus-reset event are ignored during the self-ID phase.
// - Lock response error sets when lock response retries run out without completion.
// - Posted write error sets on host bus error; offset and source recorded.
// - Receive summary bit is read-only OR of receive events ANDed with mask.
// - Transmit summary bit is read-only OR of transmit events ANDed with mask.
// - Response packet event sets for every packet stored in a response buffer.
// - Request packet event sets for every packet stored in a request buffer.
// - Response buffer done sets on descriptor completion when its interrupt condition holds.
// - Request buffer done sets on descriptor completion when its interrupt condition holds.
// - Response transmit done sets on last-output completion with interrupt condition.
// - Request transmit done sets on last-output completion with interrupt condition.
// - Ones written at set address set bits, at clear address clear them.
// - Set address reads raw events; clear address reads events ANDed with mask.
// - Event bits other than the cycle and summary bits set on the rising edge of their source, not its level.
// - Interrupt request is high while the master enable bit and any event bit with its mask are set.
`timescale 1ns/10ps
`default_nettype none
module link_interrupt_event_lower_bits
  import link_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [DATA_W-1:0] regWdata,
  output logic [DATA_W-1:0] regRdata,
  output logic regRdataValid,
  input wire logic cycleNumberLsb,
  input wire logic phyStatusIrq,
  input wire logic phyBusResetState,
  input wire logic selfIdPhase,
  input wire logic selfIdStreamDone,
  input wire logic acceptSelfIdentEnable,
  input wire logic lockResponseFail,
  input wire logic postedWriteFail,
  input wire logic [47:0] postedWriteOffset,
  input wire logic [15:0] postedWriteSource,
  output logic [47:0] failedWriteOffset,
  output logic [15:0] failedWriteSource,
  input wire logic responsePacketStored,
  input wire logic requestPacketStored,
  input wire logic [DMA_N-1:0] dmaDone,
  input wire logic [DMA_N-1:0] dmaIntCond,
  input wire logic [DATA_W-1:0] isochReceiveContextEvents,
  input wire logic [DATA_W-1:0] isochReceiveContextMask,
  input wire logic [DATA_W-1:0] isochTransmitContextEvents,
  input wire logic [DATA_W-1:0] isochTransmitContextMask,
  input wire logic [DATA_W-1:0] interruptMaskRegister,
  input wire logic upperMaskedPending,
  output logic interruptRequest
);

  logic [EVT_W-1:0] eventBits;
  logic [EVT_W-1:0] srcNow;
  logic [EVT_W-1:0] srcPrev;
  logic [EVT_W-1:0] hwRise;
  logic [EVT_W-1:0] swSet;
  logic [EVT_W-1:0] swClr;
  logic [EVT_W-1:0] clrEff;
  logic [EVT_W-1:0] next_eventBits;
  logic [EVT_W-1:0] eventView;
  logic [EVT_W-1:0] maskLow;
  logic cyclePrev;
  logic busResetRises;
  logic rxSummary;
  logic txSummary;
  logic wrSet;
  logic wrClr;

  assign maskLow = interruptMaskRegister[EVT_W-1:0];
  assign wrSet = regWrite && (regAddr == EVT_SET_OFS);
  assign wrClr = regWrite && (regAddr == EVT_CLR_OFS);

  // Level view of every latched source except the cycle bit
  always_comb
  begin
    srcNow = '0;
    srcNow[B_PHY] = phyStatusIrq;
    srcNow[B_BUSRST] = phyBusResetState;
    // Self-ID gating
    // acceptance enable qualifies
    srcNow[B_SELFID] = selfIdStreamDone && acceptSelfIdentEnable;
    srcNow[B_LOCKERR] = lockResponseFail;
    srcNow[B_PWERR] = postedWriteFail;
    srcNow[B_RESPONSE_PACKET_RECEIVED] = responsePacketStored;
    srcNow[B_REQUEST_PACKET_RECEIVED] = requestPacketStored;
    srcNow[B_DMA_LO +: DMA_N] = dmaDone & dmaIntCond;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      srcPrev <= EVT_RESET;
      cyclePrev <= 1'b0;
    end
    else
    begin
      srcPrev <= srcNow;
      cyclePrev <= cycleNumberLsb;
    end
  end

  // Edge detection per bit; cycle bit reacts to either edge
  genvar gi;
  generate
    for (gi = 0; gi < EVT_W; gi++)
    begin : g_rise
      if (gi == B_CYCLE)
      begin : g_toggle
        assign hwRise[gi] = cycleNumberLsb ^ cyclePrev;
      end
      else
      begin : g_edge
        assign hwRise[gi] = srcNow[gi] & ~srcPrev[gi] & LATCH_MASK[gi];
      end
    end
  endgenerate

  // Host writes; reserved and summary positions never latch
  // set and clear ports
  assign swSet = wrSet ? (regWdata[EVT_W-1:0] & LATCH_MASK) : '0;
  assign swClr = wrClr ? (regWdata[EVT_W-1:0] & LATCH_MASK) : '0;

  always_comb
  begin
    clrEff = swClr;
    if (selfIdPhase)
    begin
      clrEff[B_BUSRST] = 1'b0;
    end
  end

  // Any cause that turns the bus-reset bit on also kills self-ID done
  assign busResetRises = (hwRise[B_BUSRST] || swSet[B_BUSRST]) && !eventBits[B_BUSRST];

  always_comb
  begin
    next_eventBits = ((eventBits & ~clrEff) | hwRise | swSet) & LATCH_MASK;
    // self-ID done cleared with bus reset
    if (busResetRises)
    begin
      next_eventBits[B_SELFID] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      eventBits <= EVT_RESET;
    end
    else
    begin
      eventBits <= next_eventBits;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      failedWriteOffset <= PW_OFS_RESET;
      failedWriteSource <= PW_SRC_RESET;
    end
    else if (hwRise[B_PWERR])
    begin
      failedWriteOffset <= postedWriteOffset;
      failedWriteSource <= postedWriteSource;
    end
  end

  // Summaries are not latched; they follow the context registers live
  // unlatched summaries
  assign rxSummary = |(isochReceiveContextEvents & isochReceiveContextMask);
  assign txSummary = |(isochTransmitContextEvents & isochTransmitContextMask);

  always_comb
  begin
    eventView = eventBits & READ_MASK;
    eventView[B_ISORX] = rxSummary;
    eventView[B_ISOTX] = txSummary;
  end

  // Read data registered; answer one cycle after the strobe
  // raw or masked readback
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      regRdata <= '0;
      regRdataValid <= 1'b0;
    end
    else
    begin
      regRdataValid <= regRead;
      if (regRead && regAddr == EVT_SET_OFS)
      begin
        regRdata <= {{(DATA_W-EVT_W){1'b0}}, eventView};
      end
      else if (regRead && regAddr == EVT_CLR_OFS)
      begin
        regRdata <= {{(DATA_W-EVT_W){1'b0}}, eventView & maskLow};
      end
      else if (regRead)
      begin
        regRdata <= '0;
      end
    end
  end

  // Master enable lives in the mask register; it gates the pin only
  // masked request
  assign interruptRequest = interruptMaskRegister[MASTER_EN_BIT]
    && ((|(eventView & maskLow)) || upperMaskedPending);

  AST_CYCLE_SET: assert property (@(posedge clk) disable iff (rst)
    $changed(cycleNumberLsb) |=> eventBits[B_CYCLE])
    else $error("cycle event not set on toggle");

  AST_PHY_SET: assert property (@(posedge clk) disable iff (rst)
    $rose(phyStatusIrq) |=> eventBits[B_PHY])
    else $error("phy event not set");

  AST_BUSRST_SET: assert property (@(posedge clk) disable iff (rst)
    $rose(phyBusResetState) |=> eventBits[B_BUSRST])
    else $error("bus reset event not set");

  AST_SELFID_GATE: assert property (@(posedge clk) disable iff (rst)
    !acceptSelfIdentEnable && !eventBits[B_SELFID] && !swSet[B_SELFID]
    |=> !eventBits[B_SELFID])
    else $error("self-ID done set while acceptance disabled");

  AST_SELFID_CLR: assert property (@(posedge clk) disable iff (rst)
    $rose(eventBits[B_BUSRST]) |-> !eventBits[B_SELFID])
    else $error("self-ID done survived bus reset");

  AST_BUSRST_HOLD: assert property (@(posedge clk) disable iff (rst)
    eventBits[B_BUSRST] && selfIdPhase |=> eventBits[B_BUSRST])
    else $error("bus reset cleared during self-ID");

  AST_PW_RECORD: assert property (@(posedge clk) disable iff (rst)
    $rose(postedWriteFail) |=> eventBits[B_PWERR]
    && failedWriteOffset == $past(postedWriteOffset)
    && failedWriteSource == $past(postedWriteSource))
    else $error("posted write error not recorded");

  AST_ISO_RX: assert property (@(posedge clk) disable iff (rst)
    eventView[B_ISORX] == |(isochReceiveContextEvents & isochReceiveContextMask))
    else $error("receive summary wrong");

  AST_ISO_TX: assert property (@(posedge clk) disable iff (rst)
    eventView[B_ISOTX] == |(isochTransmitContextEvents & isochTransmitContextMask))
    else $error("transmit summary wrong");

  AST_SW_CLEAR: assert property (@(posedge clk) disable iff (rst)
    wrClr && regWdata[B_LOCKERR] && !hwRise[B_LOCKERR] |=> !eventBits[B_LOCKERR])
    else $error("clear write did not clear");

  AST_READ_MASKED: assert property (@(posedge clk) disable iff (rst)
    regRead && regAddr == EVT_CLR_OFS
    |=> regRdataValid && regRdata[EVT_W-1:0] == ($past(eventView) & $past(maskLow)))
    else $error("masked read wrong");

  AST_LEVEL_ONCE: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && responsePacketStored && $past(responsePacketStored) && !eventBits[B_RESPONSE_PACKET_RECEIVED]
    && !swSet[B_RESPONSE_PACKET_RECEIVED] |=> !eventBits[B_RESPONSE_PACKET_RECEIVED])
    else $error("held level set event again");

  AST_IRQ: assert property (@(posedge clk) disable iff (rst)
    interruptMaskRegister[MASTER_EN_BIT] && |(eventBits & maskLow) |-> interruptRequest)
    else $error("interrupt not raised");

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (rst)
    regRdataValid |-> regRdata[DATA_W-1:EVT_W] == '0
    && (regRdata[EVT_W-1:0] & ~READ_MASK) == '0)
    else $error("reserved bits nonzero");

  AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
    $rose(requestPacketStored) && wrClr && regWdata[B_REQUEST_PACKET_RECEIVED] |=> eventBits[B_REQUEST_PACKET_RECEIVED])
    else $error("event lost to clear");

endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the lower interrupt event bits
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) cmp(64'(g), 64'(e))
module tb;
  import link_irq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic regRdataValid;
  logic cycLsb = 1'b0;
  logic [9:0] src = 10'h000;
  logic idPhase = 1'b0;
  logic idDone = 1'b0;
  logic idAccept = 1'b0;
  logic [47:0] pwOfs = 48'h0;
  logic [15:0] pwSrc = 16'h0;
  logic [47:0] fwOfs;
  logic [15:0] fwSrc;
  logic [3:0] dmaCond = 4'hF;
  logic [31:0] rxEv = 32'h0;
  logic [31:0] rxMask = 32'h0;
  logic [31:0] txEv = 32'h0;
  logic [31:0] txMask = 32'h0;
  logic [31:0] interrupt_mask_register = 32'h0;
  logic upper = 1'b0;
  logic irq;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  // Source index to event bit: dma 3..0, packets, posted, lock, bus reset, phy
  int bitPos [10] = '{0, 1, 2, 3, 4, 5, 8, 9, 17, 19};
  link_interrupt_event_lower_bits dut (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .regRdataValid(regRdataValid), .cycleNumberLsb(cycLsb), .phyStatusIrq(src[9]),
    .phyBusResetState(src[8]), .selfIdPhase(idPhase), .selfIdStreamDone(idDone),
    .acceptSelfIdentEnable(idAccept), .lockResponseFail(src[7]), .postedWriteFail(src[6]),
    .postedWriteOffset(pwOfs), .postedWriteSource(pwSrc), .failedWriteOffset(fwOfs),
    .failedWriteSource(fwSrc), .responsePacketStored(src[5]),
    .requestPacketStored(src[4]), .dmaDone(src[3:0]), .dmaIntCond(dmaCond),
    .isochReceiveContextEvents(rxEv), .isochReceiveContextMask(rxMask),
    .isochTransmitContextEvents(txEv), .isochTransmitContextMask(txMask),
    .interruptMaskRegister(interrupt_mask_register), .upperMaskedPending(upper),
    .interruptRequest(irq));
  always #20 clk = ~clk;
  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    `CHK(regRdataValid, 1'b1);
    `CHK(regRdata, e);
    // Return on an edge so callers drive inputs there
    @(posedge clk);
  endtask
  task automatic irqIs(input logic e);
    @(posedge clk);
    #1;
    `CHK(irq, e);
    @(posedge clk);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(EVT_SET_OFS, 32'h0);
    wr(EVT_SET_OFS, 32'hFFFCFFFF);
    rd(EVT_SET_OFS, 32'h0018033F);
    rd(EVT_CLR_OFS, 32'h0);
    wr(EVT_CLR_OFS, 32'hFFFFFFFF);
    rd(EVT_SET_OFS, 32'h0);
    wr(8'h88, 32'hFFFFFFFF);
    rd(8'h88, 32'h0);
    rd(EVT_SET_OFS, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      pwOfs <= 48'h00000000A000 + 48'(i);
      pwSrc <= 16'hC000 + 16'(i);
      src[i] <= 1'b1;
      rd(EVT_SET_OFS, 32'h1 << bitPos[i]);
      wr(EVT_CLR_OFS, 32'h001FFFFF);
      rd(EVT_SET_OFS, 32'h0);
      @(posedge clk);
      src[i] <= 1'b0;
    end
    `CHK(fwOfs, 48'h00000000A006);
    `CHK(fwSrc, 16'hC006);
    // Completion without its descriptor condition must stay silent
    @(posedge clk);
    dmaCond <= 4'h0;
    src[3:0] <= 4'hF;
    rd(EVT_SET_OFS, 32'h0);
    src[3:0] <= 4'h0;
    dmaCond <= 4'hF;
    cycLsb <= 1'b1;
    rd(EVT_SET_OFS, 32'h00100000);
    wr(EVT_CLR_OFS, 32'h00100000);
    cycLsb <= 1'b0;
    rd(EVT_SET_OFS, 32'h00100000);
    wr(EVT_CLR_OFS, 32'h00100000);
    idDone <= 1'b1;
    rd(EVT_SET_OFS, 32'h0);
    idDone <= 1'b0;
    idAccept <= 1'b1;
    @(posedge clk);
    idDone <= 1'b1;
    rd(EVT_SET_OFS, 32'h00010000);
    idDone <= 1'b0;
    idPhase <= 1'b1;
    src[8] <= 1'b1;
    rd(EVT_SET_OFS, 32'h00020000);
    // Bus reset cannot be cleared by the host during the self-ID phase
    wr(EVT_CLR_OFS, 32'h00020000);
    rd(EVT_SET_OFS, 32'h00020000);
    idPhase <= 1'b0;
    wr(EVT_CLR_OFS, 32'h00020000);
    rd(EVT_SET_OFS, 32'h0);
    src[8] <= 1'b0;
    wr(EVT_SET_OFS, 32'h00000010);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= EVT_CLR_OFS;
    regWdata <= 32'h00000010;
    src[4] <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    rd(EVT_SET_OFS, 32'h00000010);
    src[4] <= 1'b0;
    wr(EVT_CLR_OFS, 32'h00000010);
    rxEv <= 32'h00FF0000;
    rxMask <= 32'h00010000;
    rd(EVT_SET_OFS, 32'h00000080);
    rxMask <= 32'h80000000;
    rd(EVT_SET_OFS, 32'h0);
    txEv <= 32'h00000001;
    txMask <= 32'h00000001;
    wr(EVT_CLR_OFS, 32'h000000C0);
    rd(EVT_SET_OFS, 32'h00000040);
    txEv <= 32'h0;
    wr(EVT_SET_OFS, 32'h0000003F);
    interrupt_mask_register <= 32'h80000005;
    rd(EVT_CLR_OFS, 32'h00000005);
    irqIs(1'b1);
    interrupt_mask_register <= 32'h00000005;
    irqIs(1'b0);
    rd(EVT_CLR_OFS, 32'h00000005);
    interrupt_mask_register <= 32'h80000000;
    upper <= 1'b1;
    irqIs(1'b1);
    upper <= 1'b0;
    interrupt_mask_register <= 32'h80000005;
    wr(EVT_CLR_OFS, 32'h00000005);
    irqIs(1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
